// ---- hw/cc_channel.sv ----
/*
  one capture/compare module: capture, software timer, high speed output,
  8/16-bit pwm and frequency output.
  assumes i_tick is already gated by run or an armed watchdog, and by debug halt, in the parent.
*/
`timescale 1ns/1ns
`default_nettype none
module cc_channel
  import counter_array_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  input  wire logic [MODE_W-1:0] i_mode,
  input  wire logic              i_cap_rise,
  input  wire logic              i_cap_fall,
  input  wire logic              i_cap_pin,
  input  wire logic              i_freeze,
  input  wire logic              i_tick,
  input  wire logic [CNT_W-1:0]  i_count,
  input  wire logic [CNT_W-1:0]  i_count_inc,
  input  wire logic              i_wr_en,
  input  wire logic [CNT_W-1:0]  i_wr_data,
  input  wire logic              i_flag_clr,
  output logic      [CNT_W-1:0]  o_cmp,
  output logic                   o_flag,
  output logic                   o_out,
  output logic                   o_out_en
);
  logic             pin_prev_reg;
  logic [CNT_W-1:0] cmp_reg;
  logic [CNT_W-1:0] cmp_next;
  logic             flag_reg;
  logic             out_reg;
  logic             out_next;
  wire              pin_rise;
  wire              pin_fall;
  wire              cap_hit;
  wire              match16;
  wire              match8;
  wire              cmp_event;

  ////////////////////////////////////////////////////////////////////////
  // event decode; matches look at the value the counter moves onto
  assign pin_rise  = i_cap_pin & ~pin_prev_reg;
  assign pin_fall  = ~i_cap_pin & pin_prev_reg;
  assign cap_hit   = (i_mode == MODE_CAPTURE) & ~i_freeze &
                     ((i_cap_rise & pin_rise) | (i_cap_fall & pin_fall));
  assign match16   = i_tick & (i_count_inc == cmp_reg);
  assign match8    = i_tick & (i_count_inc[BYTE_W-1:0] == cmp_reg[BYTE_W-1:0]);
  assign cmp_event = ((i_mode == MODE_SWTIMER) | (i_mode == MODE_HSO)) ? match16 :
                     (i_mode == MODE_FREQ) ? match8 : 1'b0;
  assign o_out_en  = (i_mode == MODE_HSO) | (i_mode == MODE_FREQ) |
                     (i_mode == MODE_PWM8) | (i_mode == MODE_PWM16);

  // compare word: hardware capture wins over software; frequency reload wins over its low byte only
  always_comb
  begin
    cmp_next = cmp_reg;
    if (i_wr_en)
      cmp_next = i_wr_data;
    if (cap_hit)
      cmp_next = i_count;
    else if ((i_mode == MODE_FREQ) && match8)
      cmp_next[BYTE_W-1:0] = cmp_reg[BYTE_W-1:0] + cmp_reg[2*BYTE_W-1:BYTE_W];
  end

  // output level per mode
  always_comb
  begin
    case (i_mode)
      MODE_HSO:   out_next = match16 ? ~out_reg : out_reg;
      MODE_FREQ:  out_next = match8 ? ~out_reg : out_reg;
      MODE_PWM8:  out_next = i_count[BYTE_W-1:0] < cmp_reg[BYTE_W-1:0];
      MODE_PWM16: out_next = i_count < cmp_reg;
      default:    out_next = 1'b0;
    endcase
  end

  // state; a set in the clear cycle wins so no event is lost
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      pin_prev_reg <= 1'b0;
      cmp_reg      <= CNT_ZERO;
      flag_reg     <= 1'b0;
      out_reg      <= 1'b0;
    end
    else
    begin
      pin_prev_reg <= i_cap_pin;
      cmp_reg      <= cmp_next;
      flag_reg     <= (cap_hit | cmp_event) | (flag_reg & ~i_flag_clr);
      out_reg      <= out_next;
    end
  end

  assign o_cmp  = cmp_reg;
  assign o_flag = flag_reg;
  assign o_out  = out_reg;

  ////////////////////////////////////////////////////////////////////////
  property p_capture_takes_count;
    @(posedge i_sys_clk) disable iff (i_reset)
    cap_hit |=> (cmp_reg == $past(i_count)) && flag_reg;
  endproperty
  a_capture_takes_count: assert property (p_capture_takes_count)
    else $error("capture did not latch the counter");

  cover property (@(posedge i_sys_clk) disable iff (i_reset) cap_hit);
  cover property (@(posedge i_sys_clk) disable iff (i_reset) (i_mode == MODE_FREQ) && match8);
endmodule
`default_nettype wire

// ---- hw/counter_array_capture_compare.sv ----
/*
  programmable counter array: shared time base with six clock sources,
  six capture/compare modules, watchdog on module 5 with lock.
  assumes module pins go through the crossbar, inputs are synchronous
  except the external count and oscillator lines, which are resynchronised.
*/
`timescale 1ns/1ns
`default_nettype none
module counter_array_capture_compare
  import counter_array_pkg::*;
(
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_reset,
  input  wire logic                      i_por,
  input  wire logic                      i_debug_halt,
  input  wire logic                      i_run,
  input  wire logic [SEL_W-1:0]          i_src_sel,
  input  wire logic                      i_timer0_ovf,
  input  wire logic                      i_external_count_input,
  input  wire logic                      i_ext_osc_clk,
  input  wire logic                      i_cnt_wr,
  input  wire logic [CNT_W-1:0]          i_cnt_wr_data,
  input  wire logic                      i_ovf_clr,
  input  wire logic [NUM_MOD*MODE_W-1:0] i_mod_mode,
  input  wire logic [NUM_MOD-1:0]        i_cap_rise,
  input  wire logic [NUM_MOD-1:0]        i_cap_fall,
  input  wire logic [NUM_MOD-1:0]        i_cap_pin,
  input  wire logic                      i_cmp_wr,
  input  wire logic [SEL_W-1:0]          i_cmp_wr_sel,
  input  wire logic [CNT_W-1:0]          i_cmp_wr_data,
  input  wire logic [NUM_MOD-1:0]        i_flag_clr,
  input  wire logic [SEL_W-1:0]          i_rd_sel,
  input  wire logic                      i_wd_service,
  input  wire logic [CNT_W-1:0]          i_wd_interval,
  input  wire logic                      i_wd_disable,
  input  wire logic                      i_wd_lock,
  output logic      [CNT_W-1:0]          o_count,
  output logic                           o_ovf_flag,
  output logic      [CNT_W-1:0]          o_rd_data,
  output logic      [NUM_MOD-1:0]        o_flag,
  output logic      [NUM_MOD-1:0]        o_mod_out,
  output logic      [NUM_MOD-1:0]        o_mod_out_en,
  output logic                           o_wd_enabled,
  output logic                           o_wd_locked,
  output logic                           o_module_watchdog_reset
);
  logic [3:0]       div12_reg;
  logic [1:0]       div4_reg;
  logic [2:0]       div8_reg;
  logic [2:0]       ext_cnt_sync_reg;
  logic [2:0]       osc_sync_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             ovf_reg;
  logic             wd_en_reg;
  logic             wd_lock_reg;
  logic             wd_fire_reg;
  logic [CNT_W-1:0] rd_data_reg;
  logic [CNT_W-1:0] cmp_word [NUM_MOD];
  wire              div12_pulse;
  wire              div4_pulse;
  wire              ext_cnt_edge;
  wire              osc_edge;
  wire              osc_div8_pulse;
  wire              src_event;
  wire              tick;
  wire  [CNT_W-1:0] count_inc;
  wire              wd_expire;

  // compare-write strobe for one module, shared by all channels
  function automatic logic cmp_write_hit(input logic wr, input logic [SEL_W-1:0] sel, input int idx);
    cmp_write_hit = wr & (sel == SEL_W'(idx));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // prescaled event strobes; prescalers hold while the core is halted
  assign div12_pulse    = (div12_reg == DIV12_LAST) & ~i_debug_halt;
  assign div4_pulse     = (div4_reg == DIV4_LAST) & ~i_debug_halt;
  assign ext_cnt_edge   = ext_cnt_sync_reg[1] & ~ext_cnt_sync_reg[2];
  assign osc_edge       = osc_sync_reg[1] & ~osc_sync_reg[2];
  assign osc_div8_pulse = osc_edge & (div8_reg == DIV8_LAST) & ~i_debug_halt;

  // source select; external oscillator path is independent of system source
  assign src_event = (i_src_sel == SRC_SYS_DIV12) ? div12_pulse :
                     (i_src_sel == SRC_SYS_DIV4)  ? div4_pulse :
                     (i_src_sel == SRC_TIMER0)    ? i_timer0_ovf :
                     (i_src_sel == SRC_EXT_COUNT) ? ext_cnt_edge :
                     (i_src_sel == SRC_SYS)       ? 1'b1 :
                     (i_src_sel == SRC_EXT_OSC8)  ? osc_div8_pulse : 1'b0;

  // an armed watchdog keeps the time base running without software
  assign tick      = src_event & (i_run | wd_en_reg) & ~i_debug_halt;
  assign count_inc = count_reg + CNT_ONE;
  assign wd_expire = wd_en_reg & tick & (count_inc == cmp_word[WD_MOD]);

  // prescaler counters and two-flop synchronisers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      div12_reg    <= 4'h0;
      div4_reg     <= 2'h0;
      div8_reg     <= 3'h0;
      ext_cnt_sync_reg <= 3'h0;
      osc_sync_reg <= 3'h0;
    end
    else
    begin
      if (!i_debug_halt)
      begin
        div12_reg <= (div12_reg == DIV12_LAST) ? 4'h0 : div12_reg + 4'h1;
        div4_reg  <= div4_reg + 2'h1;
        if (osc_edge)
          div8_reg <= div8_reg + 3'h1;
      end
      ext_cnt_sync_reg <= {ext_cnt_sync_reg[1:0], i_external_count_input};
      osc_sync_reg <= {osc_sync_reg[1:0], i_ext_osc_clk};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time base; software load wins over a count in the same cycle
  always_comb
  begin
    count_next = count_reg;
    if (i_cnt_wr)
      count_next = i_cnt_wr_data;
    else if (tick)
      count_next = count_inc;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      count_reg <= CNT_ZERO;
      ovf_reg   <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      ovf_reg   <= (tick & ~i_cnt_wr & (count_inc == CNT_ZERO)) | (ovf_reg & ~i_ovf_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog enable and lock; lock survives every reset except power-on
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || i_por)
      wd_en_reg <= 1'b1;
    else if (i_wd_disable && !wd_lock_reg && !i_wd_lock)
      wd_en_reg <= 1'b0;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_por)
      wd_lock_reg <= 1'b0;
    else if (i_wd_lock && wd_en_reg)
      wd_lock_reg <= 1'b1;
  end

  // registered reset request, one cycle wide
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      wd_fire_reg <= 1'b0;
    else
      wd_fire_reg <= wd_expire;
  end

  ////////////////////////////////////////////////////////////////////////
  // six modules on one time base; module 5 belongs to the watchdog when armed
  genvar g;
  generate
    for (g = 0; g < NUM_MOD; g++)
    begin : g_mod
      wire              is_wd  = (g == WD_MOD) && wd_en_reg;
      wire [MODE_W-1:0] mode   = is_wd ? MODE_OFF : i_mod_mode[g*MODE_W +: MODE_W];
      wire              wr_en  = is_wd ? i_wd_service : cmp_write_hit(i_cmp_wr, i_cmp_wr_sel, g);
      wire [CNT_W-1:0]  wr_dat = is_wd ? count_reg + i_wd_interval : i_cmp_wr_data;

      cc_channel u_chan
      (
        .i_sys_clk   (i_sys_clk),
        .i_reset     (i_reset),
        .i_mode      (mode),
        .i_cap_rise  (i_cap_rise[g]),
        .i_cap_fall  (i_cap_fall[g]),
        .i_cap_pin   (i_cap_pin[g]),
        .i_freeze    (i_debug_halt),
        .i_tick      (tick),
        .i_count     (count_reg),
        .i_count_inc (count_inc),
        .i_wr_en     (wr_en),
        .i_wr_data   (wr_dat),
        .i_flag_clr  (i_flag_clr[g]),
        .o_cmp       (cmp_word[g]),
        .o_flag      (o_flag[g]),
        .o_out       (o_mod_out[g]),
        .o_out_en    (o_mod_out_en[g])
      );
    end
  endgenerate

  // registered readback of a module's compare/capture word
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      rd_data_reg <= CNT_ZERO;
    else if (i_rd_sel < SEL_W'(NUM_MOD))
      rd_data_reg <= cmp_word[i_rd_sel];
    else
      rd_data_reg <= CNT_ZERO;
  end

  assign o_count                 = count_reg;
  assign o_ovf_flag              = ovf_reg;
  assign o_rd_data               = rd_data_reg;
  assign o_wd_enabled            = wd_en_reg;
  assign o_wd_locked             = wd_lock_reg;
  assign o_module_watchdog_reset = wd_fire_reg;

  ////////////////////////////////////////////////////////////////////////
  property p_wd_on_after_reset;
    @(posedge i_sys_clk) i_reset |=> wd_en_reg;
  endproperty
  a_wd_on_after_reset: assert property (p_wd_on_after_reset)
    else $error("watchdog not armed after reset");

  property p_wd_disable;
    @(posedge i_sys_clk) disable iff (i_reset || i_por)
    i_wd_disable && !wd_lock_reg && !i_wd_lock |=> !wd_en_reg;
  endproperty
  a_wd_disable: assert property (p_wd_disable)
    else $error("watchdog disable ignored while unlocked");

  property p_wd_lock_holds;
    @(posedge i_sys_clk) disable iff (i_por)
    wd_lock_reg && wd_en_reg |=> wd_en_reg && wd_lock_reg;
  endproperty
  a_wd_lock_holds: assert property (p_wd_lock_holds)
    else $error("locked watchdog was turned off");

  property p_wd_fire;
    @(posedge i_sys_clk) disable iff (i_reset)
    wd_en_reg && tick && (count_inc == cmp_word[WD_MOD]) |=> o_module_watchdog_reset ##1 !o_module_watchdog_reset;
  endproperty
  a_wd_fire: assert property (p_wd_fire)
    else $error("watchdog expiry gave no single reset pulse");

  property p_halt_freezes;
    @(posedge i_sys_clk) disable iff (i_reset)
    i_debug_halt && !i_cnt_wr |=> $stable(count_reg);
  endproperty
  a_halt_freezes: assert property (p_halt_freezes)
    else $error("time base moved during debug halt");

  property p_div12_spacing;
    @(posedge i_sys_clk) disable iff (i_reset)
    div12_pulse |=> (!div12_pulse)[*8] ##1 (!div12_pulse)[*3];
  endproperty
  a_div12_spacing: assert property (p_div12_spacing)
    else $error("divide by 12 strobe too frequent");

  property p_div4_spacing;
    @(posedge i_sys_clk) disable iff (i_reset)
    div4_pulse |=> (!div4_pulse)[*3];
  endproperty
  a_div4_spacing: assert property (p_div4_spacing)
    else $error("divide by 4 strobe too frequent");

  property p_count_step;
    @(posedge i_sys_clk) disable iff (i_reset)
    tick && !i_cnt_wr |=> count_reg == CNT_W'($past(count_reg) + CNT_ONE);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("time base did not advance by one");

  property p_ext_cnt_sync;
    @(posedge i_sys_clk) disable iff (i_reset)
    $rose(i_external_count_input) |-> ##2 ext_cnt_edge;
  endproperty
  a_ext_cnt_sync: assert property (p_ext_cnt_sync)
    else $error("external count edge not seen two cycles later");

  cover property (@(posedge i_sys_clk) disable iff (i_reset) o_module_watchdog_reset);
  cover property (@(posedge i_sys_clk) disable iff (i_reset) i_debug_halt && src_event);
  cover property (@(posedge i_sys_clk) disable iff (i_reset) osc_div8_pulse && tick);
endmodule
`default_nettype wire

// ---- pkg/counter_array_pkg.sv ----
/*
  constants shared by the counter array: widths, clock source codes,
  module mode codes, prescaler terminal counts.
  assumes one system clock and a synchronous active high reset.
*/
// What this block does
// - one shared 16-bit counter as time base
// - six selectable time base clock sources
// - each module selects capture, timer, output or pwm
// - module 5 can act as watchdog reset
// - watchdog enabled on module 5 after reset
// - software may disable the watchdog
// - lock keeps watchdog on until power-on reset
// - counting and modules freeze under debug halt
// - module pins reach ports only through crossbar
// - external oscillator source counts while system runs internally
`default_nettype none
package counter_array_pkg;
  localparam int CNT_W   = 16;
  localparam int BYTE_W  = 8;
  localparam int NUM_MOD = 6;
  localparam int WD_MOD  = 5;
  localparam int SEL_W   = 3;
  localparam int MODE_W  = 3;

  // time base clock source codes
  localparam logic [SEL_W-1:0] SRC_SYS_DIV12 = 3'h0;
  localparam logic [SEL_W-1:0] SRC_SYS_DIV4  = 3'h1;
  localparam logic [SEL_W-1:0] SRC_TIMER0    = 3'h2;
  localparam logic [SEL_W-1:0] SRC_EXT_COUNT = 3'h3;
  localparam logic [SEL_W-1:0] SRC_SYS       = 3'h4;
  localparam logic [SEL_W-1:0] SRC_EXT_OSC8  = 3'h5;

  // prescaler terminal counts (divide by 12, 4 and 8)
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [2:0] DIV8_LAST  = 3'h7;

  // capture/compare module modes
  localparam logic [MODE_W-1:0] MODE_OFF     = 3'h0;
  localparam logic [MODE_W-1:0] MODE_CAPTURE = 3'h1;
  localparam logic [MODE_W-1:0] MODE_SWTIMER = 3'h2;
  localparam logic [MODE_W-1:0] MODE_HSO     = 3'h3;
  localparam logic [MODE_W-1:0] MODE_PWM8    = 3'h4;
  localparam logic [MODE_W-1:0] MODE_PWM16   = 3'h5;
  localparam logic [MODE_W-1:0] MODE_FREQ    = 3'h6;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
endpackage
`default_nettype wire

// ---- tb/counter_array_capture_compare_bench.sv ----
/*
  self-checking bench: reset, clock sources, halt, watchdog, overflow,
  capture, output modes, pwm, compare match, watchdog lock.
  assumes ext_pin_model drives the asynchronous count and oscillator pins.
*/
`timescale 1ns/1ns
`default_nettype none
module counter_array_capture_compare_bench
  import counter_array_pkg::*;
();
  localparam int P_CNT = 0, P_OVF = 1, P_SVC = 2, P_DIS = 3, P_LCK = 4, P_T0 = 5, P_EC = 6, P_OSC = 7, P_CMP = 8;
  logic                      i_sys_clk = 1'b0;
  logic                      i_reset = 1'b1, i_por = 1'b1, i_debug_halt = 1'b0, i_run = 1'b1;
  logic                      i_timer0_ovf = 1'b0, i_cnt_wr = 1'b0, i_ovf_clr = 1'b0, i_cmp_wr = 1'b0;
  logic                      i_wd_service = 1'b0, i_wd_disable = 1'b0, i_wd_lock = 1'b0;
  logic                      count_req = 1'b0, osc_burst = 1'b0;
  logic                      i_external_count_input, i_ext_osc_clk, o_ovf_flag;
  logic                      o_wd_enabled, o_wd_locked, o_module_watchdog_reset;
  logic [SEL_W-1:0]          i_src_sel = SRC_SYS, i_cmp_wr_sel = 3'h0, i_rd_sel = 3'h0;
  logic [CNT_W-1:0]          i_cnt_wr_data = 16'h0000, i_cmp_wr_data = 16'h0000, i_wd_interval = 16'h0000;
  logic [CNT_W-1:0]          o_count, o_rd_data;
  logic [NUM_MOD*MODE_W-1:0] i_mod_mode = '0;
  logic [NUM_MOD-1:0]        i_cap_rise = '0, i_cap_fall = '0, i_cap_pin = '0, i_flag_clr = '0;
  logic [NUM_MOD-1:0]        o_flag, o_mod_out, o_mod_out_en;
  logic [31:0]               seed = 32'h3d12b9c2;
  int                        bad_count = 0, num_checks = 0, wd_pulses = 0;

  counter_array_capture_compare i_counter_array_capture_compare (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_por(i_por), .i_debug_halt(i_debug_halt), .i_run(i_run), .i_src_sel(i_src_sel),
    .i_timer0_ovf(i_timer0_ovf), .i_external_count_input(i_external_count_input), .i_ext_osc_clk(i_ext_osc_clk),
    .i_cnt_wr(i_cnt_wr), .i_cnt_wr_data(i_cnt_wr_data), .i_ovf_clr(i_ovf_clr), .i_mod_mode(i_mod_mode),
    .i_cap_rise(i_cap_rise), .i_cap_fall(i_cap_fall), .i_cap_pin(i_cap_pin), .i_cmp_wr(i_cmp_wr),
    .i_cmp_wr_sel(i_cmp_wr_sel), .i_cmp_wr_data(i_cmp_wr_data), .i_flag_clr(i_flag_clr), .i_rd_sel(i_rd_sel),
    .i_wd_service(i_wd_service), .i_wd_interval(i_wd_interval), .i_wd_disable(i_wd_disable),
    .i_wd_lock(i_wd_lock), .o_count(o_count), .o_ovf_flag(o_ovf_flag), .o_rd_data(o_rd_data), .o_flag(o_flag),
    .o_mod_out(o_mod_out), .o_mod_out_en(o_mod_out_en), .o_wd_enabled(o_wd_enabled),
    .o_wd_locked(o_wd_locked), .o_module_watchdog_reset(o_module_watchdog_reset));
  ext_pin_model i_ext_pin_model (.i_sys_clk(i_sys_clk), .i_count_req(count_req), .i_osc_burst(osc_burst),
    .o_ext_count(i_external_count_input), .o_ext_osc(i_ext_osc_clk));

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a tally of watchdog reset pulses so pulse width shows up
  always #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_module_watchdog_reset === 1'b1) wd_pulses <= wd_pulses + 1;

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // compare when called; design outputs are checked after the falling edge so the design's updates have landed
  task automatic chk(input string what, input logic [CNT_W-1:0] exp, input logic [CNT_W-1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  function automatic logic [CNT_W-1:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic pwm_exp(input logic [MODE_W-1:0] m, input logic [CNT_W-1:0] c, r);
    return (m == MODE_PWM8) ? (c[7:0] < r[7:0]) : (c < r);
  endfunction
  task automatic strobe(input int k, input logic v);
    case (k)
      P_CNT: i_cnt_wr <= v;
      P_OVF: i_ovf_clr <= v;
      P_SVC: i_wd_service <= v;
      P_DIS: i_wd_disable <= v;
      P_LCK: i_wd_lock <= v;
      P_T0: i_timer0_ovf <= v;
      P_EC: count_req <= v;
      P_OSC: osc_burst <= v;
      default: i_cmp_wr <= v;
    endcase
  endtask
  // one-cycle strobe; ends on an edge so the next call starts one later
  task automatic pulse(input int k);
    cyc(1);
    strobe(k, 1'b1);
    cyc(1);
    strobe(k, 1'b0);
  endtask
  task automatic load(input logic [CNT_W-1:0] v);
    cyc(1);
    i_cnt_wr_data <= v;
    pulse(P_CNT);
  endtask
  task automatic wr_cmp(input logic [SEL_W-1:0] s, input logic [CNT_W-1:0] v);
    cyc(1);
    i_cmp_wr_sel <= s;
    i_cmp_wr_data <= v;
    pulse(P_CMP);
  endtask
  task automatic do_reset(input logic por);
    cyc(1);
    i_reset <= 1'b1;
    i_por <= por;
    cyc(16);
    i_reset <= 1'b0;
    i_por <= 1'b0;
  endtask
  // count steps over a window; windows are whole prescaler periods
  task automatic rate(input logic [SEL_W-1:0] s, input int n, k, reps, input logic [CNT_W-1:0] exp);
    logic [CNT_W-1:0] c0;
    cyc(1);
    i_src_sel <= s;
    cyc(3);
    @(negedge i_sys_clk);
    c0 = o_count;
    repeat (reps)
    begin
      pulse(k);
      cyc(6);
    end
    cyc(n);
    @(negedge i_sys_clk);
    chk("count step", exp, o_count - c0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    cyc(20000);
    $display("MISMATCH run length expected end seen timeout");
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    logic [CNT_W-1:0] v, r;
    logic [MODE_W-1:0] md;
    int n0, i, mi;
    cyc(16);
    i_reset <= 1'b0;
    i_por <= 1'b0;
    @(negedge i_sys_clk);
    chk("reset count", 16'h0000, o_count);
    chk("reset outs", 16'h0000, {o_flag, o_mod_out, o_ovf_flag, o_module_watchdog_reset});
    chk("reset wd", 16'h0002, {o_wd_enabled, o_wd_locked});
    $display("test reset done");
    rate(SRC_SYS, 24, 0, 0, 16'd24);
    rate(SRC_SYS_DIV4, 24, 0, 0, 16'd6);
    rate(SRC_SYS_DIV12, 24, 0, 0, 16'd2);
    rate(SRC_TIMER0, 4, P_T0, 5, 16'd5);
    rate(SRC_EXT_COUNT, 10, P_EC, 3, 16'd3);
    rate(SRC_EXT_OSC8, 70, P_OSC, 1, 16'd2);
    rate(3'h6, 24, 0, 0, 16'd0);
    cyc(1);
    i_debug_halt <= 1'b1;
    rate(SRC_SYS, 24, 0, 0, 16'd0);
    cyc(1);
    i_debug_halt <= 1'b0;
    $display("test sources done");
    // watchdog: regular service keeps it quiet, a lapse fires once
    i_src_sel <= SRC_SYS;
    i_wd_interval <= 16'h0014;
    n0 = wd_pulses;
    repeat (4)
    begin
      pulse(P_SVC);
      cyc(10);
    end
    chk("wd quiet", n0, wd_pulses);
    pulse(P_SVC);
    for (i = 0; i < 40 && wd_pulses == n0; i++) cyc(1);
    cyc(3);
    chk("wd pulses", n0 + 1, wd_pulses);
    chk("wd delay ok", 16'h0001, (i >= 15 && i <= 25));
    pulse(P_DIS);
    @(negedge i_sys_clk);
    chk("wd off", 16'h0000, o_wd_enabled);
    // with the watchdog off, run low must stop the time base
    cyc(1);
    i_run <= 1'b0;
    rate(SRC_SYS, 24, 0, 0, 16'd0);
    cyc(1);
    i_run <= 1'b1;
    // overflow with the watchdog off, so the wrap cannot trip it
    load(16'hfffe);
    cyc(4);
    @(negedge i_sys_clk);
    chk("ovf set", 16'h0001, o_ovf_flag);
    pulse(P_OVF);
    @(negedge i_sys_clk);
    chk("ovf clr", 16'h0000, o_ovf_flag);
    chk("wd silent", n0 + 1, wd_pulses);
    $display("test watchdog done");
    // capture on every module, the last pass with the core halted
    cyc(1);
    i_src_sel <= 3'h6;
    for (int m = 0; m < 7; m++)
    begin
      mi = m % 6;
      v = rnd();
      load(v);
      i_mod_mode[3*mi +: 3] <= MODE_CAPTURE;
      i_cap_rise[mi] <= 1'b1;
      i_cap_fall[mi] <= (m == 3);
      i_rd_sel <= mi[SEL_W-1:0];
      i_debug_halt <= (m == 6);
      cyc(2);
      i_cap_pin[mi] <= 1'b1;
      cyc(3);
      @(negedge i_sys_clk);
      chk("cap flag", {15'h0, m != 6}, o_flag[mi]);
      if (m != 6) chk("cap word", v, o_rd_data);
      cyc(1);
      i_flag_clr[mi] <= 1'b1;
      i_debug_halt <= 1'b0;
      cyc(1);
      i_flag_clr[mi] <= 1'b0;
      i_cap_pin[mi] <= 1'b0;
      cyc(3);
      @(negedge i_sys_clk);
      chk("fall cap", {15'h0, m == 3}, o_flag[mi]);
      cyc(1);
      i_mod_mode[3*mi +: 3] <= MODE_OFF;
      i_cap_rise[mi] <= 1'b0;
      i_cap_fall[mi] <= 1'b0;
    end
    // output enable across every mode code
    for (int k = 0; k < 7; k++)
    begin
      cyc(1);
      i_mod_mode[2:0] <= k[2:0];
      i_rd_sel <= {2'h3, k[0]};
      cyc(1);
      @(negedge i_sys_clk);
      chk("out en", {15'h0, k >= 3}, o_mod_out_en[0]);
      chk("rd none", 16'h0000, o_rd_data);
    end
    // pwm levels on still counts, first pass with a zero compare
    for (int t = 0; t < 8; t++)
    begin
      md = (t < 4) ? MODE_PWM8 : MODE_PWM16;
      v = rnd();
      r = rnd();
      if (t == 0) r = 16'h0000;
      load(v);
      wr_cmp(3'h1, r);
      i_mod_mode[5:3] <= md;
      cyc(3);
      @(negedge i_sys_clk);
      chk("pwm out", {15'h0, pwm_exp(md, v, r)}, o_mod_out[1]);
    end
    $display("test modes done");
    // software timer match lands as the count steps onto the compare
    load(16'h0100);
    wr_cmp(3'h2, 16'h0105);
    wr_cmp(3'h3, 16'h0105);
    i_mod_mode[11:6] <= {MODE_HSO, MODE_SWTIMER};
    i_src_sel <= SRC_SYS;
    for (i = 0; i < 20 && o_flag[2] !== 1'b1; i++) @(negedge i_sys_clk);
    chk("match flag", 16'h0001, o_flag[2]);
    chk("match count", 16'h0105, o_count);
    chk("hso out", 16'h0001, o_mod_out[3]);
    // lock survives system reset, only power-on clears it
    do_reset(1'b1);
    pulse(P_LCK);
    pulse(P_DIS);
    @(negedge i_sys_clk);
    chk("locked", 16'h0003, {o_wd_enabled, o_wd_locked});
    do_reset(1'b0);
    pulse(P_DIS);
    @(negedge i_sys_clk);
    chk("still locked", 16'h0003, {o_wd_enabled, o_wd_locked});
    do_reset(1'b1);
    pulse(P_DIS);
    pulse(P_LCK);
    @(negedge i_sys_clk);
    chk("unlocked", 16'h0000, {o_wd_enabled, o_wd_locked});
    $display("test lock done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- tb/ext_pin_model.sv ----
/*
  pin side model: external count pin and external oscillator.
  assumes count requests are one-cycle pulses at least 8 cycles apart.
*/
`timescale 1ns/1ns
`default_nettype none
module ext_pin_model
(
  input  wire logic i_sys_clk,
  input  wire logic i_count_req,
  input  wire logic i_osc_burst,
  output var  logic o_ext_count = 1'b0,
  output var  logic o_ext_osc = 1'b0
);
  // count pin: one 3-cycle high pulse per request, idles low
  always @(posedge i_sys_clk)
  begin
    if (i_count_req === 1'b1)
    begin
      o_ext_count <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      o_ext_count <= 1'b0;
    end
  end
  // oscillator: 16 edges at 14 ns, phase unrelated, still between bursts
  always @(posedge i_osc_burst)
  begin
    #3;
    repeat (16)
    begin
      o_ext_osc = 1'b1;
      #7;
      o_ext_osc = 1'b0;
      #7;
    end
  end
endmodule
`default_nettype wire
